// >>> logic/dap_port_ctrl.sv
// Conversion sequencing and parallel host port of a dual 12-bit converter.
// Assumes all host pins and the converter clock pin are asynchronous to clock,
// and that converted words for both channels arrive on result_a and result_b.
// Notes on behaviour
// - Busy high in hold, low when done
// - Start strobe falling edge enters hold immediately
// - Conversion begins on next converter clock rise
// - Port answers only while chip select low
// - Chip select high: ignore read and write strobes, release bus
// - Read strobe fall presents next output word
// - Write strobe rise captures bus word
// - Busy drops after fourteenth converter clock rise
`timescale 1ns/1ps
module dap_port_ctrl
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic conversion_start_strobe,
	input wire logic adc_clock_pin,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [dap_pkg::DATA_W-1:0] data_bus_in,
	input wire logic [dap_pkg::DATA_W-1:0] result_a,
	input wire logic [dap_pkg::DATA_W-1:0] result_b,
	output logic [dap_pkg::DATA_W-1:0] data_bus_out,
	output logic data_bus_oe,
	output logic busy,
	output logic hold_mode,
	output logic [dap_pkg::DATA_W-1:0] config_word,
	output logic config_valid
);
	import dap_pkg::*;

	logic [16:0] pins_raw;
	logic [16:0] pins_f;
	logic cvst_f;
	logic aclk_f;
	logic cs_f;
	logic rd_f;
	logic wr_f;
	logic [DATA_W-1:0] din_f;
	logic cvst_prev_r;
	logic aclk_prev_r;
	logic rd_prev_r;
	logic wr_prev_r;
	logic cvst_fall;
	logic aclk_rise;
	logic rd_fall;
	logic wr_rise;
	dap_state_e state_r;
	logic [3:0] edge_cnt_r;
	logic [DATA_W-1:0] word_a_r;
	logic [DATA_W-1:0] word_b_r;
	logic next_is_b_r;
	logic busy_r;
	logic hold_r;
	logic [DATA_W-1:0] dout_r;
	logic oe_r;
	logic [DATA_W-1:0] cfg_r;
	logic cfg_valid_r;

	// All checks below run on the system clock and sleep through reset
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// All pins idle high except the converter clock; data bus lanes in the low bits
	assign pins_raw = {conversion_start_strobe, adc_clock_pin, cs_n, rd_n, wr_n, data_bus_in};

	// Reset levels match the idle pins, so no false edge follows reset
	dap_pin_sync #(
		.WIDTH(17),
		.RST_VAL({5'h17, DATA_RST})
	) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.pin(pins_raw),
		.level(pins_f)
	);

	assign cvst_f = pins_f[16];
	assign aclk_f = pins_f[15];
	assign cs_f = pins_f[14];
	assign rd_f = pins_f[13];
	assign wr_f = pins_f[12];
	assign din_f = pins_f[DATA_W-1:0];

	// Previous filtered levels for edge detection
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cvst_prev_r <= 1'b1;
			aclk_prev_r <= 1'b0;
			rd_prev_r <= 1'b1;
			wr_prev_r <= 1'b1;
		end
		else
		begin
			cvst_prev_r <= cvst_f;
			aclk_prev_r <= aclk_f;
			rd_prev_r <= rd_f;
			wr_prev_r <= wr_f;
		end
	end

	assign cvst_fall = cvst_prev_r && !cvst_f;
	assign aclk_rise = !aclk_prev_r && aclk_f;
	assign rd_fall = rd_prev_r && !rd_f;
	assign wr_rise = !wr_prev_r && wr_f;

	// Conversion sequence; a start strobe during a conversion is ignored so the
	// held sample is never disturbed mid-conversion
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= DAP_SAMPLE;
			edge_cnt_r <= CNT_RST;
			busy_r <= 1'b0;
			hold_r <= 1'b0;
		end
		else
		begin
			unique case (state_r)
				DAP_SAMPLE:
				begin
					if (cvst_fall)
					begin
						// Hold does not wait for the converter clock
						state_r <= DAP_HOLD;
						hold_r <= 1'b1;
						busy_r <= 1'b1;
					end
				end
				DAP_HOLD:
				begin
					if (aclk_rise)
					begin
						state_r <= DAP_CONVERT;
						edge_cnt_r <= 4'h1;
					end
				end
				DAP_CONVERT:
				begin
					if (aclk_rise)
					begin
						if (edge_cnt_r == CONV_EDGES - 4'h1)
						begin
							state_r <= DAP_SAMPLE;
							edge_cnt_r <= CNT_RST;
							busy_r <= 1'b0;
							hold_r <= 1'b0;
						end
						else
							edge_cnt_r <= edge_cnt_r + 4'h1;
					end
				end
			endcase
		end
	end

	// Result words land when the conversion completes; read order restarts at A
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			word_a_r <= DATA_RST;
			word_b_r <= DATA_RST;
			next_is_b_r <= 1'b0;
		end
		else if (state_r == DAP_CONVERT && aclk_rise && edge_cnt_r == CONV_EDGES - 4'h1)
		begin
			word_a_r <= result_a;
			word_b_r <= result_b;
			next_is_b_r <= 1'b0;
		end
		else if (rd_fall && !cs_f)
			next_is_b_r <= !next_is_b_r;
	end

	// Read side: drive from read strobe fall until it rises or chip select leaves
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dout_r <= DATA_RST;
			oe_r <= 1'b0;
		end
		else if (cs_f)
			oe_r <= 1'b0;
		else if (rd_fall)
		begin
			// Bit eleven of the word sits on the bus msb lane
			dout_r <= next_is_b_r ? word_b_r : word_a_r;
			oe_r <= 1'b1;
		end
		else if (rd_f)
			oe_r <= 1'b0;
	end

	// Write side: capture on the write strobe rise, only while selected
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_r <= DATA_RST;
			cfg_valid_r <= 1'b0;
		end
		else
		begin
			cfg_valid_r <= wr_rise && !cs_f;
			if (wr_rise && !cs_f)
				cfg_r <= din_f;
		end
	end

	assign data_bus_out = dout_r;
	assign data_bus_oe = oe_r;
	assign busy = busy_r;
	assign hold_mode = hold_r;
	assign config_word = cfg_r;
	assign config_valid = cfg_valid_r;

	a_busy_rise: assert property (state_r == DAP_SAMPLE && cvst_fall |=> busy_r && hold_r)
		else $error("busy did not rise on start strobe");
	a_hold_entry: assert property (state_r == DAP_SAMPLE && cvst_fall |=> state_r == DAP_HOLD)
		else $error("hold not entered on start strobe");
	a_conv_start: assert property (state_r == DAP_HOLD && aclk_rise |=> edge_cnt_r == 4'h1)
		else $error("conversion did not start on first clock rise");
	a_busy_drop: assert property (state_r == DAP_CONVERT && aclk_rise && edge_cnt_r == CONV_EDGES - 4'h1
		|=> !busy_r && state_r == DAP_SAMPLE)
		else $error("busy did not drop after fourteenth edge");
	a_busy_held: assert property (busy_r && !(state_r == DAP_CONVERT && aclk_rise) |=> busy_r)
		else $error("busy dropped before conversion end");
	a_cs_release: assert property (cs_f |=> !data_bus_oe)
		else $error("bus driven while deselected");
	a_read_drive: assert property (rd_fall && !cs_f |=> data_bus_oe && data_bus_out ==
		($past(next_is_b_r) ? $past(word_b_r) : $past(word_a_r)))
		else $error("read did not present next word");
	a_write_capture: assert property (wr_rise && !cs_f |=> config_valid && config_word == $past(din_f))
		else $error("write word not captured");
	a_write_ignored: assert property (wr_rise && cs_f |=> !config_valid && $stable(config_word))
		else $error("write accepted while deselected");
endmodule

// >>> logic/dap_pkg.sv
// Shared constants for the dual converter parallel port control block.
// Assumes a single 125 MHz system clock and active-low asynchronous reset.
package dap_pkg;
	// Parallel data bus width, bit 11 is the most significant
	localparam int DATA_W = 12;
	// Converter clock rising edges from conversion start to end of busy
	localparam logic [3:0] CONV_EDGES = 4'he;
	// Input synchroniser depth for pins from outside the clock domain
	localparam int SYNC_STAGES = 3;
	// Reset values
	localparam logic [11:0] DATA_RST = 12'h000;
	localparam logic [3:0] CNT_RST = 4'h0;
	// Converter sequence states
	typedef enum logic [1:0] {DAP_SAMPLE, DAP_HOLD, DAP_CONVERT} dap_state_e;
endpackage

// >>> logic/dap_pin_sync.sv
// Three-flop pin synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous pins; output changes once stages two and three agree.
`timescale 1ns/1ps
module dap_pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_lane
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic lvl_r;
			// First stage is read only by the second stage to keep metastability contained
			always_ff @(posedge clock or negedge rst_n)
			begin
				if (!rst_n)
				begin
					s1_r <= RST_VAL[i];
					s2_r <= RST_VAL[i];
					s3_r <= RST_VAL[i];
					lvl_r <= RST_VAL[i];
				end
				else
				begin
					s1_r <= pin[i];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r)
						lvl_r <= s3_r; // Only settled values pass
				end
			end
			// One flop per lane keeps each output bit with a single driver
			assign level[i] = lvl_r;
		end
	endgenerate
endmodule

// >>> testbench/dap_host_model.sv
// Host model for the parallel port: strobes, converter clock and the shared bus wire.
// Assumes the bench calls step() from one thread, one pin set per call.
`timescale 1ns/1ps
module dap_host_model
(
	input wire logic clock,
	input wire logic [dap_pkg::DATA_W-1:0] data_bus_out,
	input wire logic data_bus_oe,
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic conversion_start_strobe,
	output logic adc_clock_pin,
	output logic [dap_pkg::DATA_W-1:0] data_bus_in
);
	import dap_pkg::*;
	logic host_oe_r;
	logic [DATA_W-1:0] wdata_r;
	logic [DATA_W-1:0] last_r = '0;
	// A released wire shows the inverse of its last level, so stale data never matches
	assign data_bus_in = host_oe_r ? wdata_r : (data_bus_oe ? data_bus_out : ~last_r);
	// Remember only driven levels, so a released wire holds one steady inverse
	always @(posedge clock)
		if (host_oe_r || data_bus_oe)
			last_r <= data_bus_in;
	// Idle pins: deselected, strobes high, converter clock low
	initial
	begin
		{cs_n, rd_n, wr_n, conversion_start_strobe, adc_clock_pin} = 5'h1e;
		host_oe_r = 1'b0;
		wdata_r = '0;
	end
	// Pins change just after an edge and hold eight clocks so the filters settle
	task automatic step(input logic cs, rd, wr, st, ck, oe, input logic [DATA_W-1:0] d);
		@(posedge clock);
		cs_n <= cs;
		rd_n <= rd;
		wr_n <= wr;
		conversion_start_strobe <= st;
		adc_clock_pin <= ck;
		host_oe_r <= oe;
		wdata_r <= d;
		repeat (8) @(posedge clock);
	endtask
endmodule

// >>> testbench/dual_adc_parallel_port_control_tb_top.sv
// Self-checking bench for the converter control and parallel port.
// Assumes the host model drives every pin; results are fixed bench words.
`timescale 1ns/1ps
module dual_adc_parallel_port_control_tb_top;
	import dap_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n, rd_n, wr_n, conversion_start_strobe, adc_clock_pin;
	logic [DATA_W-1:0] data_bus_in, data_bus_out, config_word;
	logic [DATA_W-1:0] result_a = 12'ha5c;
	logic [DATA_W-1:0] result_b = 12'h3c1;
	logic data_bus_oe, busy, hold_mode, config_valid;
	int err_total = 0;
	int checked = 0;
	int cycles = 0;
	int pulses = 0;
	always #4 clock = ~clock;
	dap_port_ctrl dut_u (.clock, .rst_n, .conversion_start_strobe, .adc_clock_pin, .cs_n, .rd_n,
		.wr_n, .data_bus_in, .result_a, .result_b, .data_bus_out, .data_bus_oe, .busy,
		.hold_mode, .config_word, .config_valid);
	dap_host_model host_u (.clock, .data_bus_out, .data_bus_oe, .cs_n, .rd_n, .wr_n,
		.conversion_start_strobe, .adc_clock_pin, .data_bus_in);
	// Counting pulses catches a write strobe that fires twice or not at all
	always @(posedge clock)
	begin
		cycles++;
		if (config_valid === 1'b1)
			pulses++;
		if (cycles == 5000)
		begin
			err_total++;
			close_out();
		end
	end
	task automatic cmp(input string what, input logic [DATA_W-1:0] exp, got);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Busy must hold through thirteen converter clock rises and drop after the fourteenth
	task automatic test_convert();
		host_u.step(1, 1, 1, 0, 0, 0, '0);
		cmp("busy", 12'h001, DATA_W'(busy));
		cmp("hold_mode", 12'h001, DATA_W'(hold_mode));
		for (int k = 1; k <= 14; k++)
		begin
			host_u.step(1, 1, 1, 0, 1, 0, '0);
			cmp("busy", (k == 14) ? 12'h000 : 12'h001, DATA_W'(busy));
			host_u.step(1, 1, 1, 0, 0, 0, '0);
		end
		cmp("hold_mode", 12'h000, DATA_W'(hold_mode));
		host_u.step(1, 1, 1, 1, 0, 0, '0);
		$display("test_convert done");
	endtask
	// Two reads give channel A then B; deselect releases the bus and blocks reads
	task automatic test_read();
		host_u.step(0, 1, 1, 1, 0, 0, '0);
		host_u.step(0, 0, 1, 1, 0, 0, '0);
		cmp("oe", 12'h001, DATA_W'(data_bus_oe));
		cmp("data", result_a, data_bus_out);
		host_u.step(0, 1, 1, 1, 0, 0, '0);
		cmp("oe", 12'h000, DATA_W'(data_bus_oe));
		host_u.step(0, 0, 1, 1, 0, 0, '0);
		cmp("data", result_b, data_bus_out);
		host_u.step(1, 0, 1, 1, 0, 0, '0);
		cmp("oe", 12'h000, DATA_W'(data_bus_oe));
		host_u.step(1, 1, 1, 1, 0, 0, '0);
		host_u.step(1, 0, 1, 1, 0, 0, '0);
		cmp("oe", 12'h000, DATA_W'(data_bus_oe));
		host_u.step(1, 1, 1, 1, 0, 0, '0);
		// The ignored read must not advance the order: A comes next again
		host_u.step(0, 1, 1, 1, 0, 0, '0);
		host_u.step(0, 0, 1, 1, 0, 0, '0);
		cmp("data", result_a, data_bus_out);
		cmp("oe", 12'h001, DATA_W'(data_bus_oe));
		host_u.step(0, 1, 1, 1, 0, 0, '0);
		host_u.step(1, 1, 1, 1, 0, 0, '0);
		$display("test_read done");
	endtask
	// A selected write lands once; a deselected one leaves the word alone
	task automatic test_write();
		int n;
		n = pulses;
		host_u.step(0, 1, 0, 1, 0, 1, 12'h9e3);
		host_u.step(0, 1, 1, 1, 0, 1, 12'h9e3);
		cmp("config_word", 12'h9e3, config_word);
		cmp("pulses", DATA_W'(n + 1), DATA_W'(pulses));
		host_u.step(1, 1, 0, 1, 0, 1, 12'h456);
		host_u.step(1, 1, 1, 1, 0, 1, 12'h456);
		host_u.step(1, 1, 1, 1, 0, 0, '0);
		cmp("config_word", 12'h9e3, config_word);
		cmp("pulses", DATA_W'(n + 1), DATA_W'(pulses));
		$display("test_write done");
	endtask
	task automatic close_out();
		$display("Counts: %0d checked, %0d mismatches", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		test_convert();
		test_read();
		test_write();
		close_out();
	end
endmodule
